// ### common/pdc_map.vh
`ifndef PDC_MAP_VH
`define PDC_MAP_VH
// ==========================================================
// serial word framing
`define PDC_WORD_W        24
`define PDC_CNT_W         5
`define PDC_CNT_LAST      5'h17
`define PDC_CNT_ZERO      5'h00
`define PDC_ADDR_HI       3
`define PDC_ADDR_LO       0
// ==========================================================
// post-reset settle count
`define PDC_SETTLE_ZERO   3'h0
`define PDC_SETTLE_ONE    3'h1
`define PDC_SETTLE_END    3'h6
// ==========================================================
// word addresses (low four bits)
`define PDC_ADR_W0        4'h0
`define PDC_ADR_W1        4'h3
`define PDC_ADR_W2        4'h5
`define PDC_ADR_W3        4'h7
`define PDC_ADR_W4        4'h9
// ==========================================================
// word one fields
`define PDC_W1_RFPD       23
`define PDC_W1_RFP        22
`define PDC_W1_RFR_HI     21
`define PDC_W1_RFR_LO     16
// word two fields
`define PDC_W2_IFPD       23
`define PDC_W2_IFN_HI     22
`define PDC_W2_IFN_LO     4
// word three fields
`define PDC_W3_ACC_HI     23
`define PDC_W3_ACC_LO     20
`define PDC_W3_CPG_HI     19
`define PDC_W3_CPG_LO     16
`define PDC_W3_IFR_HI     15
`define PDC_W3_IFR_LO     4
// word four fields
`define PDC_W4_AUTO_POWERUP       23
// ==========================================================
// reset values
`define PDC_RST_RFR       6'h01
`define PDC_RST_IFN       19'h0_0038
`define PDC_RST_IFR       12'h003
`define PDC_RST_ACC       4'h1
`define PDC_RST_CPG       4'h0
`define PDC_RST_PD        1'b1
`define PDC_RST_AUTO_POWERUP      1'b0
`endif

// ### core/pdc_sync.v
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser with agreement filter on stages two and three
module pdc_sync (
  input  wire ref_clk,
  input  wire arst_n,
  input  wire din,
  output reg  dout_ff
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  // ==========================================================
  // shift chain
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout_ff <= s3_ff;
      end
    end
  end
endmodule // pdc_sync
`default_nettype wire

// ### core/pdc_top.v
// How it works
// - rf reference divider is six-bit unsigned, values one to sixty-three
// - prescaler select clear picks 8/9/12/13, set picks 16/17/20/21
// - rf powerdown bit one powers rf loop down, pump high impedance
// - chip enable low always powers rf loop down
// - chip enable high with auto powerup forces rf loop up
// - otherwise rf powerdown bit alone decides rf loop state
// - if powerdown bit one powers if loop down, pump high impedance
// - auto powerup plus word zero write clears if powerdown bit
// - chip enable low keeps if loop powered down
// - if reference divider twelve bits, host programs three to 4095
// - access bits in word three; bit zero must be one
// - auto powerup is word four bit 23, reset disabled
`timescale 1ns/1ps
`default_nettype none
`include "pdc_map.vh"
module pdc_top (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        ser_clk,
  input  wire        ser_data,
  input  wire        ser_le,
  input  wire        chip_en,
  output reg  [5:0]  rf_ref_divider_ff,
  output reg         rf_prescaler_select_ff,
  output reg         rf_power_on_ff,
  output reg         rf_pump_oe_ff,
  output reg  [18:0] if_feedback_divider_ff,
  output reg  [11:0] if_ref_divider_ff,
  output reg  [3:0]  rf_pump_gain_ff,
  output reg  [3:0]  access_bits_ff,
  output reg         auto_powerup_ff,
  output reg         if_power_on_ff,
  output reg         if_pump_oe_ff,
  output reg         word_done_ff
);
  // synchronised pins
  wire                   clk_s;
  wire                   data_s;
  wire                   le_s;
  wire                   ce_s;
  // edge history and post-reset settle count
  reg                    clk_d_ff;
  reg                    le_d_ff;
  reg  [2:0]             settle_ff;
  wire                   settled;
  // serial shifter
  reg  [`PDC_WORD_W-1:0] shift_ff;
  reg  [`PDC_CNT_W-1:0]  cnt_ff;
  reg                    full_ff;
  // software power-down bits and next power state
  reg                    rf_powerdown_bit_ff;
  reg                    if_powerdown_bit_ff;
  reg                    nxt_rf_on;
  reg                    nxt_if_on;
  // decoded strobes
  wire                   clk_rise;
  wire                   le_rise;
  wire                   commit;
  wire [3:0]             adr;

  // ==========================================================
  // pin synchronisers
  pdc_sync u_sclk (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     (ser_clk),
    .dout_ff (clk_s)
  );
  pdc_sync u_sdat (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     (ser_data),
    .dout_ff (data_s)
  );
  pdc_sync u_sle (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     (ser_le),
    .dout_ff (le_s)
  );
  pdc_sync u_ce (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     (chip_en),
    .dout_ff (ce_s)
  );

  assign clk_rise = clk_s & ~clk_d_ff;
  // latch edges are ignored until the synchronisers hold real pin levels
  assign le_rise  = le_s & ~le_d_ff & settled;
  assign settled  = (settle_ff == `PDC_SETTLE_END);

  // latch only a complete word
  assign commit   = le_rise & full_ff;
  assign adr      = shift_ff[`PDC_ADDR_HI:`PDC_ADDR_LO];

  // ==========================================================
  // settle count: synchronisers leave reset low while an idle
  // latch enable pin is high, which would mimic a latch edge
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_ff <= `PDC_SETTLE_ZERO;
    end else if (!settled) begin
      settle_ff <= settle_ff + `PDC_SETTLE_ONE;
    end
  end

  // ==========================================================
  // serial shifter, msb first, counts bits since last latch
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_d_ff <= 1'b0;
      le_d_ff  <= 1'b0;
      shift_ff <= {`PDC_WORD_W{1'b0}};
      cnt_ff   <= `PDC_CNT_ZERO;
      full_ff  <= 1'b0;
    end else begin
      clk_d_ff <= clk_s;
      le_d_ff  <= le_s;
      if (le_rise) begin
        cnt_ff  <= `PDC_CNT_ZERO;
        full_ff <= 1'b0;
      end else if (clk_rise && !le_s) begin
        shift_ff <= {shift_ff[`PDC_WORD_W-2:0], data_s};
        if (cnt_ff == `PDC_CNT_LAST) begin
          full_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // configuration word decode
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_ref_divider_ff      <= `PDC_RST_RFR;
      rf_prescaler_select_ff <= 1'b0;
      rf_powerdown_bit_ff    <= `PDC_RST_PD;
      if_feedback_divider_ff <= `PDC_RST_IFN;
      if_powerdown_bit_ff    <= `PDC_RST_PD;
      if_ref_divider_ff      <= `PDC_RST_IFR;
      rf_pump_gain_ff        <= `PDC_RST_CPG;
      access_bits_ff         <= `PDC_RST_ACC;
      auto_powerup_ff        <= `PDC_RST_AUTO_POWERUP;
      word_done_ff           <= 1'b0;
    end else begin
      // one pulse per committed word, any address
      word_done_ff <= commit;
      if (commit) begin
        case (adr)
          `PDC_ADR_W0: begin
            // word zero write with auto powerup wakes if loop
            if (auto_powerup_ff) begin
              if_powerdown_bit_ff <= 1'b0;
            end
          end
          `PDC_ADR_W1: begin
            rf_powerdown_bit_ff    <= shift_ff[`PDC_W1_RFPD];
            rf_prescaler_select_ff <= shift_ff[`PDC_W1_RFP];
            rf_ref_divider_ff      <= shift_ff[`PDC_W1_RFR_HI:`PDC_W1_RFR_LO];
          end
          `PDC_ADR_W2: begin
            if_powerdown_bit_ff    <= shift_ff[`PDC_W2_IFPD];
            // legality of the value is the host's concern
            if_feedback_divider_ff <= shift_ff[`PDC_W2_IFN_HI:`PDC_W2_IFN_LO];
          end
          `PDC_ADR_W3: begin
            access_bits_ff    <= shift_ff[`PDC_W3_ACC_HI:`PDC_W3_ACC_LO];
            rf_pump_gain_ff   <= shift_ff[`PDC_W3_CPG_HI:`PDC_W3_CPG_LO];
            if_ref_divider_ff <= shift_ff[`PDC_W3_IFR_HI:`PDC_W3_IFR_LO];
          end
          `PDC_ADR_W4: begin
            auto_powerup_ff <= shift_ff[`PDC_W4_AUTO_POWERUP];
          end
          default: begin
            // unknown address: word_done pulses, no field moves
          end
        endcase
      end
    end
  end

  // ==========================================================
  // power precedence: chip enable, then auto powerup (rf loop only), then bit
  always @* begin
    nxt_rf_on = 1'b0;
    nxt_if_on = 1'b0;
    if (!ce_s) begin
      nxt_rf_on = 1'b0;
      nxt_if_on = 1'b0;
    end else begin
      // auto powerup outranks the rf bit
      if (auto_powerup_ff) begin
        nxt_rf_on = 1'b1;
      end else begin
        nxt_rf_on = ~rf_powerdown_bit_ff;
      end
      nxt_if_on = ~if_powerdown_bit_ff;
    end
  end

  // registered power and pump enable outputs
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_power_on_ff <= 1'b0;
      rf_pump_oe_ff  <= 1'b0;
      if_power_on_ff <= 1'b0;
      if_pump_oe_ff  <= 1'b0;
    end else begin
      // a pump drives only while its loop runs
      rf_power_on_ff <= nxt_rf_on;
      rf_pump_oe_ff  <= nxt_rf_on;
      if_power_on_ff <= nxt_if_on;
      if_pump_oe_ff  <= nxt_if_on;
    end
  end
endmodule // pdc_top
`default_nettype wire

// ### sim/pdc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================
// host: shifts words into serial pins
module pdc_host (
  input  wire logic ref_clk,
  output var logic  ser_clk,
  output var logic  ser_data,
  output var logic  ser_le
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b1;
  end
  // msb first, clock idle low outside frames
  task automatic send(input logic [23:0] w, input integer nbits);
    integer i;
    begin
      @(posedge ref_clk) ser_le <= 1'b0;
      for (i = nbits - 1; i >= 0; i--) begin
        @(posedge ref_clk) ser_data <= w[i];
        repeat (3) @(posedge ref_clk);
        ser_clk <= 1'b1;
        repeat (6) @(posedge ref_clk);
        ser_clk <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
      ser_le <= 1'b1;
      ser_data <= ~w[0]; // released line shows inverse
    end
  endtask
endmodule // pdc_host
`default_nettype wire

// ### sim/pdc_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================
// port checker
module pdc_props (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        ser_le,
  input wire logic        chip_en,
  input wire logic [5:0]  rf_ref_divider_ff,
  input wire logic [18:0] if_feedback_divider_ff,
  input wire logic [11:0] if_ref_divider_ff,
  input wire logic        auto_powerup_ff,
  input wire logic        rf_power_on_ff,
  input wire logic        rf_pump_oe_ff,
  input wire logic        if_power_on_ff,
  input wire logic        if_pump_oe_ff,
  input wire logic        word_done_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // power precedence and pump enables
  rf_chip_off_a: assert property (!chip_en [*8] |-> !rf_power_on_ff)
    else $error("rf loop on with chip enable low");
  if_chip_off_a: assert property (!chip_en [*8] |-> !if_power_on_ff)
    else $error("if loop on with chip enable low");
  rf_auto_up_a: assert property ((chip_en && auto_powerup_ff) [*8] |-> rf_power_on_ff)
    else $error("rf loop off under auto powerup");
  rf_pump_pair_a: assert property (rf_pump_oe_ff == rf_power_on_ff)
    else $error("rf pump enable differs from rf power");
  if_pump_pair_a: assert property (if_pump_oe_ff == if_power_on_ff)
    else $error("if pump enable differs from if power");
  // word commit framing
  field_commit_a: assert property ($changed({rf_ref_divider_ff, if_feedback_divider_ff,
    if_ref_divider_ff, auto_powerup_ff}) |-> word_done_ff) else $error("field moved without commit");
  done_pulse_a: assert property (word_done_ff |=> !word_done_ff)
    else $error("word done longer than one cycle");
  le_quiet_a: assert property (!ser_le [*8] |-> !word_done_ff)
    else $error("commit without latch enable rise");
endmodule // pdc_props
bind pdc_top pdc_props u_props (.ref_clk(ref_clk), .arst_n(arst_n), .ser_le(ser_le),
  .chip_en(chip_en), .rf_ref_divider_ff(rf_ref_divider_ff),
  .if_feedback_divider_ff(if_feedback_divider_ff), .if_ref_divider_ff(if_ref_divider_ff),
  .auto_powerup_ff(auto_powerup_ff), .rf_power_on_ff(rf_power_on_ff),
  .rf_pump_oe_ff(rf_pump_oe_ff), .if_power_on_ff(if_power_on_ff),
  .if_pump_oe_ff(if_pump_oe_ff), .word_done_ff(word_done_ff));
`default_nettype wire

// ### sim/test_pll_divider_powerdown_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_map.vh"
module test_pll_divider_powerdown_config;
  logic        ref_clk, arst_n, chip_en;
  wire         ser_clk, ser_data, ser_le, rf_prescaler_select_ff, rf_power_on_ff;
  wire         rf_pump_oe_ff, auto_powerup_ff, if_power_on_ff, if_pump_oe_ff, word_done_ff;
  wire  [5:0]  rf_ref_divider_ff;
  wire  [18:0] if_feedback_divider_ff;
  wire  [11:0] if_ref_divider_ff;
  wire  [3:0]  rf_pump_gain_ff, access_bits_ff;
  integer      miscompares, n_checks, i, k, m_rfr, m_rfp, m_rfpd, m_ifn, m_ifpd;
  integer      m_ifr, m_cpg, m_acc, m_auto_powerup;
  logic [31:0] r;
  pdc_host u_host (.ref_clk, .ser_clk, .ser_data, .ser_le);
  pdc_top u_dut (.ref_clk, .arst_n, .ser_clk, .ser_data, .ser_le, .chip_en, .rf_ref_divider_ff,
    .rf_prescaler_select_ff, .rf_power_on_ff, .rf_pump_oe_ff, .if_feedback_divider_ff,
    .if_ref_divider_ff, .rf_pump_gain_ff, .access_bits_ff, .auto_powerup_ff,
    .if_power_on_ff, .if_pump_oe_ff, .word_done_ff);
  // ==================================
  // checking
  task automatic print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_checks++;
      if (seen !== exp) begin
        miscompares++;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task automatic cmp_all;
    begin
      check("rf_ref", rf_ref_divider_ff, m_rfr);
      check("rf_presc", rf_prescaler_select_ff, m_rfp);
      check("if_fb", if_feedback_divider_ff, m_ifn);
      check("if_ref", if_ref_divider_ff, m_ifr);
      check("access", access_bits_ff, m_acc);
      check("gain", rf_pump_gain_ff, m_cpg);
      check("auto_powerup", auto_powerup_ff, m_auto_powerup);
      check("rf_pwr", {rf_power_on_ff, rf_pump_oe_ff}, {2{chip_en && (m_auto_powerup || !m_rfpd)}});
      check("if_pwr", {if_power_on_ff, if_pump_oe_ff}, {2{chip_en && !m_ifpd}});
    end
  endtask
  // model reset values
  task automatic model_reset;
    begin
      m_rfr = 1;
      m_rfp = 0;
      m_rfpd = 1;
      m_ifn = 56;
      m_ifpd = 1;
      m_ifr = 3;
      m_cpg = 0;
      m_acc = 1;
      m_auto_powerup = 0;
    end
  endtask
  // one word: update model, send, await commit
  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    begin
      if (a == `PDC_ADR_W0 && m_auto_powerup) m_ifpd = 0;
      if (a == `PDC_ADR_W1) begin
        m_rfpd = d[19];
        m_rfp = d[18];
        m_rfr = d[17:12];
      end
      if (a == `PDC_ADR_W2) begin
        m_ifpd = d[19];
        m_ifn = d[18:0];
      end
      if (a == `PDC_ADR_W3) begin
        m_acc = d[19:16];
        m_cpg = d[15:12];
        m_ifr = d[11:0];
      end
      if (a == `PDC_ADR_W4) m_auto_powerup = d[19];
      u_host.send({d, a}, 24);
      k = 0;
      while (word_done_ff !== 1'b1 && k < 100) begin
        @(posedge ref_clk) #1 k++;
      end
      if (k >= 100) begin
        miscompares++;
        print_verdict();
      end
      repeat (3) @(posedge ref_clk);
      #1 cmp_all();
    end
  endtask
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ==================================
  // main sequence
  initial begin
    {arst_n, chip_en, miscompares, n_checks} = '0;
    model_reset();
    r = $urandom(32'hd02ad835);
    @(posedge ref_clk) chip_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 cmp_all();
    for (i = 0; i < 6; i++) begin
      r = $urandom;
      wr(`PDC_ADR_W1, {r[1:0], 6'(1 + $urandom % 63), r[15:4]});
      wr(`PDC_ADR_W2, {r[2], 19'(240 + $urandom % 524048)});
      wr(`PDC_ADR_W3, {r[6:4], 1'b1, r[11:8], 12'(3 + $urandom % 4093)});
      wr(`PDC_ADR_W4, {r[3], 19'h2_0010});
      wr(`PDC_ADR_W0, r[31:12]);
    end
    wr(4'h2, r[19:0]);
    // a frame cut short of a full word must not commit
    u_host.send({20'hF_FFFF, `PDC_ADR_W1}, 20);
    k = 0;
    repeat (20) @(posedge ref_clk) #1 k = k + word_done_ff;
    check("short_done", k, 0);
    cmp_all();
    wr(`PDC_ADR_W2, {1'b1, 19'h0_00F0});
    wr(`PDC_ADR_W4, 20'h2_0010);
    wr(`PDC_ADR_W0, 20'h0_0000);
    wr(`PDC_ADR_W1, 20'hC_1000);
    wr(`PDC_ADR_W4, 20'hA_0010);
    wr(`PDC_ADR_W0, 20'h0_0000);
    @(posedge ref_clk) chip_en <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 cmp_all();
    @(posedge ref_clk) chip_en <= 1'b1;
    wr(`PDC_ADR_W4, 20'h0_0000);
    // reset again in mid-run: every field back to its reset value
    @(posedge ref_clk) arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    model_reset();
    repeat (8) @(posedge ref_clk);
    #1 cmp_all();
    wr(`PDC_ADR_W1, {r[1:0], 6'h3F, r[15:4]});
    print_verdict();
  end
endmodule // test_pll_divider_powerdown_config
`default_nettype wire
